// *** inc/syc_pkg.sv ***
// constants and carrier types of the synthesizer programming controller
// What this block does
// - Level wait field passes; software sizes it.
// - Lock settle field passes; software sizes it.
// - Low nibble of each word selects register.
// - ADC word bits 23,22 ones, others zero.
// - Divisor is ceiling((pfd/100k-2)/4), max 255.
// - Reserved word always sent as fixed value.
// - Resync count field passes; software sizes it.
// - Resync unused forces the count to one.
// - Resync word bits 10,4 ones, others zero.
// - Low PFD power-up: 12 down to 1, wait, 0.
// - High PFD: lock at half, rewrite 4,2,1,0.
// - Update: 10,4 reset,2,1,0,4 clear,wait,0 cal.
// - High PFD update repeats 4,2,1,0 for target.
package syc_pkg;
    // apb map, byte addresses
    localparam logic [7:0]  SYC_OFF_TABLE  = 8'h00;
    localparam logic [7:0]  SYC_OFF_TARGET = 8'h34;
    localparam logic [7:0]  SYC_OFF_CTRL   = 8'h44;
    localparam logic [7:0]  SYC_OFF_WAIT   = 8'h48;
    localparam logic [7:0]  SYC_OFF_PFD    = 8'h4c;
    localparam logic [7:0]  SYC_OFF_STATUS = 8'h50;
    localparam int          SYC_NUM_WORDS  = 17;
    // control register bits
    localparam int          SYC_CTRL_INIT  = 0;
    localparam int          SYC_CTRL_UPD   = 1;
    localparam int          SYC_CTRL_HIGH  = 2;
    localparam int          SYC_CTRL_NORSY = 3;
    localparam int          SYC_CTRL_CLRD  = 4;
    // device word layout
    localparam logic [3:0]  SYC_SEL_ADC    = 4'ha;
    localparam logic [3:0]  SYC_SEL_FIXED  = 4'hb;
    localparam logic [3:0]  SYC_SEL_RESYNC = 4'hc;
    localparam logic [31:0] SYC_FIXED_WORD = 32'h0061300b;
    localparam logic [17:0] SYC_ADC_RSVD   = 18'h00300;
    localparam logic [11:0] SYC_RSY_RSVD   = 12'h041;
    localparam logic [15:0] SYC_RSY_OFF    = 16'h0001;
    localparam logic [7:0]  SYC_ADC_MAX    = 8'hff;
    localparam int          SYC_ADC_LSB    = 6;
    localparam int          SYC_RESET_BIT  = 4;
    localparam int          SYC_AUTO_CALIBRATION    = 21;
    // reset values
    localparam logic [15:0] SYC_PFD_RESET  = 16'h0000;
    localparam int          SYC_CLK_NS     = 8;
    localparam int          SYC_WAIT_NS    = 161000;
    localparam logic [31:0] SYC_WAIT_RESET =
        32'((SYC_WAIT_NS + SYC_CLK_NS - 1) / SYC_CLK_NS);
    localparam int          SYC_SCLK_DIV   = 4;
    // sequence step encodings
    localparam logic [1:0]  SYC_K_SEND     = 2'h0;
    localparam logic [1:0]  SYC_K_WAIT     = 2'h1;
    localparam logic [1:0]  SYC_K_END      = 2'h2;
    localparam logic [2:0]  SYC_M_NONE     = 3'h0;
    localparam logic [2:0]  SYC_M_RST_SET  = 3'h1;
    localparam logic [2:0]  SYC_M_RST_CLR  = 3'h2;
    localparam logic [2:0]  SYC_M_AC_CLR   = 3'h3;
    localparam logic [2:0]  SYC_M_AC_SET   = 3'h4;

    typedef struct packed {
        logic [1:0] kind;
        logic [4:0] src;
        logic [2:0] modv;
    } syc_step_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } syc_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } syc_apb_rsp_type;

    typedef struct packed {
        logic sclk;
        logic sdata;
        logic le;
    } syc_pins_type;
endpackage

// *** core/syc_shifter.sv ***
// serial word shifter for the three-wire programming port
`timescale 1ns/1ps
module syc_shifter
    import syc_pkg::*;
#(
    parameter int CLK_DIV = SYC_SCLK_DIV
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         start,
    input  wire logic [31:0]  word,
    output logic              busy,
    output logic              done,
    output syc_pins_type      pins
);
    initial begin
        if (CLK_DIV < 1 || CLK_DIV > 255) begin
            $error("CLK_DIV out of range");
        end
    end

    typedef struct packed {
        logic [7:0]   div;
        logic [31:0]  sh;
        logic [5:0]   bits;
        logic         phase;
        logic         active;
        logic         latch;
        logic         done;
        syc_pins_type pins;
    } syc_sh_type;

    syc_sh_type s_reg;
    syc_sh_type s_next;
    logic       tick;

    assign tick = (s_reg.div == 8'h00);
    assign busy = s_reg.active;
    assign done = s_reg.done;
    assign pins = s_reg.pins;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        s_next      = s_reg;
        s_next.done = 1'b0;
        if (!s_reg.active || tick) begin
            s_next.div = 8'(CLK_DIV - 1);
        end else begin
            s_next.div = s_reg.div - 8'h01;
        end
        if (!s_reg.active) begin
            if (start) begin
                s_next.active = 1'b1;
                s_next.sh     = word;
                s_next.bits   = 6'd0;
                s_next.phase  = 1'b0;
                s_next.latch  = 1'b0;
            end
        end else if (tick) begin
            if (s_reg.latch) begin
                // device takes the word on the load strobe
                if (s_reg.pins.le) begin
                    s_next.pins.le = 1'b0;
                    s_next.active  = 1'b0;
                    s_next.done    = 1'b1;
                end else begin
                    s_next.pins.le = 1'b1;
                end
            end else if (!s_reg.phase) begin
                s_next.pins.sclk  = 1'b0;
                s_next.pins.sdata = s_reg.sh[31];
                s_next.phase      = 1'b1;
            end else begin
                // data stood a full tick before the rising edge
                s_next.pins.sclk = 1'b1;
                s_next.sh        = {s_reg.sh[30:0], 1'b0};
                s_next.phase     = 1'b0;
                s_next.bits      = s_reg.bits + 6'd1;
                if (s_reg.bits == 6'd31) begin
                    s_next.latch = 1'b1;
                end
            end
        end
        if (s_reg.latch && s_reg.pins.sclk && tick) begin
            s_next.pins.sclk = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

// *** core/syc_ctrl.sv ***
// apb-programmed host sequencer for the synthesizer register set
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module syc_ctrl
    import syc_pkg::*;
#(
    parameter int CLK_DIV = SYC_SCLK_DIV
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire syc_apb_req_type apb_req,
    output syc_apb_rsp_type      apb_rsp,
    output syc_pins_type         pins
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_SHIFT,
        ST_PAUSE
    } syc_state_type;

    typedef struct packed {
        logic [SYC_NUM_WORDS-1:0][31:0] words;
        logic                           high_pfd;
        logic                           no_resync;
        logic [31:0]                    wait_cfg;
        logic [15:0]                    pfd_100k;
        syc_state_type                  state;
        logic                           upd;
        logic [4:0]                     idx;
        logic [31:0]                    cnt;
        logic                           go;
        logic [31:0]                    out_word;
        logic                           done;
        logic [31:0]                    prdata;
    } syc_ctrl_type;

    syc_ctrl_type c_reg;
    syc_ctrl_type c_next;
    logic         sh_busy;
    logic         sh_done;
    syc_step_type step;
    logic [7:0]   adc_div;
    logic         setup;
    logic         access;
    logic         wr;
    logic         in_table;
    logic         bad_addr;
    logic         busy;
    logic [4:0]   tbl_idx;

    ////////////////////////////////////////////////////////////////////
    // helpers

    // register number that a table entry programs
    function automatic logic [3:0] reg_of(input logic [4:0] src);
        logic [3:0] r;
        r = 4'h0;
        if (src < 5'd13) begin
            r = src[3:0];
        end else if (src == 5'd13) begin
            r = 4'h4;
        end else if (src == 5'd14) begin
            r = 4'h2;
        end else if (src == 5'd15) begin
            r = 4'h1;
        end
        return r;
    endfunction

    // ceiling((pfd/100k - 2)/4) with pfd given in 100 kHz units
    function automatic logic [7:0] adc_div_of(input logic [15:0] x);
        logic [16:0] t;
        logic [7:0]  d;
        t = ({1'b0, x} + 17'h00001) >> 2;
        d = t[7:0];
        if (x <= 16'h0002) begin
            d = 8'h01;
        end else if (t > {9'h000, SYC_ADC_MAX}) begin
            d = SYC_ADC_MAX;
        end
        return d;
    endfunction

    function automatic syc_step_type mk(input logic [1:0] k,
                                        input logic [4:0] s,
                                        input logic [2:0] m);
        syc_step_type t;
        t.kind = k;
        t.src  = s;
        t.modv = m;
        return t;
    endfunction

    // step i of power-up (upd=0) or frequency update (upd=1)
    function automatic syc_step_type step_of(input logic       upd,
                                             input logic       high,
                                             input logic [4:0] i);
        syc_step_type t;
        logic [4:0]   tail;
        t    = mk(SYC_K_END, 5'd0, SYC_M_NONE);
        tail = upd ? 5'd8 : 5'd14;
        if (!upd && i < 5'd12) begin
            t = mk(SYC_K_SEND, 5'd12 - i, SYC_M_NONE);
        end else if (!upd && i == 5'd12) begin
            t = mk(SYC_K_WAIT, 5'd0, SYC_M_NONE);
        end else if (!upd && i == 5'd13) begin
            // high pfd first locks at half rate with calibration on
            t = mk(SYC_K_SEND, 5'd0,
                   high ? SYC_M_AC_SET : SYC_M_NONE);
        end else if (upd && i < 5'd8) begin
            case (i[2:0])
                3'd0: t = mk(SYC_K_SEND, 5'd10, SYC_M_NONE);
                3'd1: t = mk(SYC_K_SEND, 5'd4, SYC_M_RST_SET);
                3'd2: t = mk(SYC_K_SEND, 5'd2, SYC_M_NONE);
                3'd3: t = mk(SYC_K_SEND, 5'd1, SYC_M_NONE);
                3'd4: t = mk(SYC_K_SEND, 5'd0, SYC_M_AC_CLR);
                3'd5: t = mk(SYC_K_SEND, 5'd4, SYC_M_RST_CLR);
                3'd6: t = mk(SYC_K_WAIT, 5'd0, SYC_M_NONE);
                default: t = mk(SYC_K_SEND, 5'd0, SYC_M_AC_SET);
            endcase
        end else if (high && i >= tail && i < tail + 5'd4) begin
            // target rate words 4,2,1,0, last one uncalibrated
            t = mk(SYC_K_SEND, 5'd13 + (i - tail),
                   (i == tail + 5'd3) ? SYC_M_AC_CLR
                                      : SYC_M_NONE);
        end
        return t;
    endfunction

    // final word with select nibble, fixed fields and step edits
    function automatic logic [31:0] shape(input logic [4:0]  src,
                                          input logic [31:0] raw,
                                          input logic [2:0]  m,
                                          input logic [7:0]  div,
                                          input logic        norsy);
        logic [31:0] w;
        logic [3:0]  r;
        r      = reg_of(src);
        w      = raw;
        w[3:0] = r;
        if (r == SYC_SEL_ADC) begin
            w[31:14] = SYC_ADC_RSVD;
            w[SYC_ADC_LSB +: 8] = div;
        end else if (r == SYC_SEL_FIXED) begin
            w = SYC_FIXED_WORD;
        end else if (r == SYC_SEL_RESYNC) begin
            w[15:4] = SYC_RSY_RSVD;
            if (norsy) begin
                w[31:16] = SYC_RSY_OFF;
            end
        end
        case (m)
            SYC_M_RST_SET: w[SYC_RESET_BIT] = 1'b1;
            SYC_M_RST_CLR: w[SYC_RESET_BIT] = 1'b0;
            SYC_M_AC_CLR:  w[SYC_AUTO_CALIBRATION]   = 1'b0;
            SYC_M_AC_SET:  w[SYC_AUTO_CALIBRATION]   = 1'b1;
            default:       w = w;
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // bus decode

    assign setup    = apb_req.psel && !apb_req.penable;
    assign access   = apb_req.psel && apb_req.penable;
    assign wr       = access && apb_req.pwrite;
    assign busy     = (c_reg.state != ST_IDLE);
    assign tbl_idx  = apb_req.paddr[6:2];
    assign in_table = (apb_req.paddr < SYC_OFF_CTRL);
    assign adc_div  = adc_div_of(c_reg.pfd_100k);
    assign step     = step_of(c_reg.upd, c_reg.high_pfd, c_reg.idx);

    always_comb begin
        bad_addr = 1'b0;
        if (apb_req.paddr[1:0] != 2'b00) begin
            bad_addr = 1'b1;
        end else if (in_table) begin
            // words may not change under a running sequence
            bad_addr = apb_req.pwrite && busy;
        end else if (apb_req.paddr == SYC_OFF_CTRL) begin
            bad_addr = 1'b0;
        end else if (apb_req.paddr == SYC_OFF_WAIT) begin
            bad_addr = 1'b0;
        end else if (apb_req.paddr == SYC_OFF_PFD) begin
            bad_addr = 1'b0;
        end else if (apb_req.paddr == SYC_OFF_STATUS) begin
            bad_addr = apb_req.pwrite;
        end else begin
            bad_addr = 1'b1;
        end
    end

    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.pslverr = access && bad_addr;
    assign apb_rsp.prdata  = c_reg.prdata;

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        c_next    = c_reg;
        c_next.go = 1'b0;
        if (setup) begin
            c_next.prdata = 32'h00000000;
            if (apb_req.paddr[1:0] != 2'b00) begin
                c_next.prdata = 32'h00000000;
            end else if (in_table) begin
                c_next.prdata = c_reg.words[tbl_idx];
            end else if (apb_req.paddr == SYC_OFF_CTRL) begin
                c_next.prdata[SYC_CTRL_HIGH]  = c_reg.high_pfd;
                c_next.prdata[SYC_CTRL_NORSY] = c_reg.no_resync;
            end else if (apb_req.paddr == SYC_OFF_WAIT) begin
                c_next.prdata = c_reg.wait_cfg;
            end else if (apb_req.paddr == SYC_OFF_PFD) begin
                c_next.prdata[15:0] = c_reg.pfd_100k;
            end else if (apb_req.paddr == SYC_OFF_STATUS) begin
                c_next.prdata[0]     = busy;
                c_next.prdata[1]     = c_reg.done;
                c_next.prdata[12:8]  = c_reg.idx;
                c_next.prdata[23:16] = adc_div;
            end
        end
        if (wr && !bad_addr) begin
            if (in_table) begin
                c_next.words[tbl_idx] = apb_req.pwdata;
            end else if (apb_req.paddr == SYC_OFF_CTRL) begin
                c_next.high_pfd  = apb_req.pwdata[SYC_CTRL_HIGH];
                c_next.no_resync = apb_req.pwdata[SYC_CTRL_NORSY];
                if (apb_req.pwdata[SYC_CTRL_CLRD]) begin
                    c_next.done = 1'b0;
                end
                // a start while busy is ignored
                if (!busy && (apb_req.pwdata[SYC_CTRL_INIT] ||
                              apb_req.pwdata[SYC_CTRL_UPD])) begin
                    c_next.state = ST_RUN;
                    c_next.idx   = 5'd0;
                    c_next.upd   = !apb_req.pwdata[SYC_CTRL_INIT];
                end
            end else if (apb_req.paddr == SYC_OFF_WAIT) begin
                c_next.wait_cfg = apb_req.pwdata;
            end else if (apb_req.paddr == SYC_OFF_PFD) begin
                c_next.pfd_100k = apb_req.pwdata[15:0];
            end
        end
        case (c_reg.state)
            ST_RUN: begin
                if (step.kind == SYC_K_SEND) begin
                    c_next.out_word = shape(step.src,
                                            c_reg.words[step.src],
                                            step.modv, adc_div,
                                            c_reg.no_resync);
                    c_next.go    = 1'b1;
                    c_next.state = ST_SHIFT;
                end else if (step.kind == SYC_K_WAIT) begin
                    c_next.cnt   = c_reg.wait_cfg;
                    c_next.state = ST_PAUSE;
                end else begin
                    c_next.done  = 1'b1; // set wins over clear
                    c_next.state = ST_IDLE;
                end
            end
            ST_SHIFT: begin
                if (sh_done) begin
                    c_next.idx   = c_reg.idx + 5'd1;
                    c_next.state = ST_RUN;
                end
            end
            ST_PAUSE: begin
                // wait_cfg+1 cycles, strictly more than programmed
                if (c_reg.cnt == 32'h00000000) begin
                    c_next.idx   = c_reg.idx + 5'd1;
                    c_next.state = ST_RUN;
                end else begin
                    c_next.cnt = c_reg.cnt - 32'h00000001;
                end
            end
            default: begin
                c_next.state = c_next.state;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c_reg          <= '0;
            c_reg.wait_cfg <= SYC_WAIT_RESET;
            c_reg.pfd_100k <= SYC_PFD_RESET;
            c_reg.state    <= ST_IDLE;
        end else begin
            c_reg <= c_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    syc_shifter #(
        .CLK_DIV (CLK_DIV)
    ) u_shifter (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (c_reg.go),
        .word    (c_reg.out_word),
        .busy    (sh_busy),
        .done    (sh_done),
        .pins    (pins)
    );

    logic unused_busy;
    assign unused_busy = sh_busy;
endmodule

// *** bench/syc_ctrl_assertions.sv ***
// concurrent checks on the ports of the programming controller
`timescale 1ns/1ps
module syc_ctrl_assertions
    import syc_pkg::*;
#(
    parameter int CLK_DIV = SYC_SCLK_DIV
) (
    input wire logic            pclk,
    input wire logic            presetn,
    input wire syc_apb_req_type apb_req,
    input wire syc_apb_rsp_type apb_rsp,
    input wire syc_pins_type    pins
);
    logic [7:0] bits_reg;
    logic [8:0] le_cnt_reg;
    logic       sclk_q_reg;
    logic       acc;

    assign acc = apb_req.psel && apb_req.penable;

    // rising serial clocks since the last load strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bits_reg   <= 8'h00;
            le_cnt_reg <= 9'h000;
            sclk_q_reg <= 1'b0;
        end else begin
            sclk_q_reg <= pins.sclk;
            le_cnt_reg <= pins.le ? le_cnt_reg + 9'h001 : 9'h000;
            if (pins.le)
                bits_reg <= 8'h00;
            else if (pins.sclk && !sclk_q_reg)
                bits_reg <= bits_reg + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_READY: assert property (@(posedge pclk) disable iff (!presetn)
        apb_rsp.pready) else $error("pready dropped");
    AST_ERR_PHASE: assert property (@(posedge pclk) disable iff (!presetn)
        apb_rsp.pslverr |-> acc) else $error("pslverr outside access");
    AST_RO_STATUS: assert property (@(posedge pclk) disable iff (!presetn)
        acc && apb_req.pwrite && apb_req.paddr == 8'h50 |-> apb_rsp.pslverr)
        else $error("status write accepted");
    AST_UNALIGNED: assert property (@(posedge pclk) disable iff (!presetn)
        acc && apb_req.paddr[1:0] != 2'b00 |-> apb_rsp.pslverr)
        else $error("unaligned access accepted");
    AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
        acc && !apb_req.pwrite && apb_req.paddr > 8'h50
        |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
        else $error("unmapped read not refused");
    AST_WORD_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pins.le) |-> bits_reg == 8'd32) else $error("word not 32 bits");
    AST_LE_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(pins.le) |-> le_cnt_reg == CLK_DIV)
        else $error("load strobe width wrong");
    AST_LE_CLK_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        pins.le |-> !pins.sclk) else $error("strobe with clock high");
    AST_DATA_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        pins.sclk && sclk_q_reg |-> $stable(pins.sdata))
        else $error("data moved while clock high");
endmodule

// *** bench/syc_dev_model.sv ***
// behavioural synthesizer port: shifts words in and logs every load
`timescale 1ns/1ps
module syc_dev_model
    import syc_pkg::*;
(
    input wire logic         pclk,
    input wire syc_pins_type pins
);
    logic [31:0] shift_reg;
    logic [31:0] regs [0:15];
    logic [31:0] applied;
    logic [31:0] wlog [$];
    int          tlog [$];
    int          cyc = 0;
    int          ref_div = 1;
    logic        held;
    logic [9:0]  band_timeout;
    logic [7:0]  adc_div;
    logic        adc_on;
    logic        conv_on_write;

    always @(posedge pclk) cyc <= cyc + 1;
    always @(posedge pins.sclk) shift_reg <= {shift_reg[30:0], pins.sdata};
    // fields stay until the same register is loaded again
    always @(posedge pins.le) begin
        regs[shift_reg[3:0]] = shift_reg;
        wlog.push_back(shift_reg);
        tlog.push_back(cyc);
        if (shift_reg[3:0] == 4'h0)
            applied = shift_reg;
    end
    assign held = regs[4][4];
    assign band_timeout = regs[9][23:14];
    assign adc_div = regs[10][13:6];
    assign adc_on = regs[10][4];
    assign conv_on_write = regs[10][5];
endmodule

// *** bench/synth_cal_register_programming_tb.sv ***
// self-checking bench for the synthesizer programming controller
`timescale 1ns/1ps
module synth_cal_register_programming_tb import syc_pkg::*;;
    logic            pclk;
    logic            presetn;
    syc_apb_req_type req;
    syc_apb_rsp_type rsp;
    syc_pins_type    pins;
    int              num_errors = 0;
    int              cmp_count = 0;
    int              cycles = 0;
    int              pfd;
    logic            norsy;

    syc_ctrl #(.CLK_DIV(2)) u_dut (
        .pclk    (pclk),
        .presetn (presetn),
        .apb_req (req),
        .apb_rsp (rsp),
        .pins    (pins)
    );
    syc_dev_model u_dev (
        .pclk (pclk),
        .pins (pins)
    );

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 100000) begin
            num_errors++;
            $display("BAD %0t run hung", $time);
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // a spare edge first, so a release never meets the next setup
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge pclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        q = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic ee);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
        chk({31'h0, e}, {31'h0, ee});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] x, input logic ee);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q & m, x);
        chk({31'h0, e}, {31'h0, ee});
    endtask

    // low nibble deliberately wrong so the select forcing shows
    function automatic logic [31:0] tw(int n, logic t);
        return (t ? 32'h0026002f : 32'h0015002f) | 32'(n << 8);
    endfunction

    function automatic logic [7:0] adiv(int p);
        return ((p + 1) / 4 > 255) ? 8'hff : 8'((p + 1) / 4);
    endfunction

    // code: register * 16 + bit edit, plus 256 for a target word
    function automatic logic [31:0] ew(int c);
        int          n;
        logic [31:0] w;
        n = (c >> 4) & 15;
        w = tw(n, c[8]);
        w[3:0] = 4'(n);
        case (c & 15)
            1: w[4] = 1'b1;
            2: w[4] = 1'b0;
            3: w[21] = 1'b0;
            4: w[21] = 1'b1;
            default: ;
        endcase
        if (n == 10) w[31:6] = {18'h00300, adiv(pfd)};
        if (n == 11) w = 32'h0061300b;
        if (n == 12) w[31:4] = {norsy ? 16'h1 : w[31:16], 12'h041};
        return w;
    endfunction

    task automatic seqchk(input int s[$], input int p);
        int g0;
        int g1;
        chk(32'(u_dev.wlog.size()), 32'(s.size()));
        foreach (s[i])
            if (i < u_dev.wlog.size())
                chk(u_dev.wlog[i], ew(s[i]));
        g0 = u_dev.tlog[p] - u_dev.tlog[p - 1];
        g1 = u_dev.tlog[p - 1] - u_dev.tlog[p - 2];
        chk(32'(g0 >= g1 + 4), 32'h1);
        u_dev.wlog.delete();
        u_dev.tlog.delete();
    endtask

    task automatic run(input int p, input logic [31:0] c);
        int          tn [4] = '{4, 2, 1, 0};
        logic [31:0] st = 32'h0;
        logic        e;
        pfd = p;
        norsy = c[3];
        for (int n = 0; n < 13; n++)
            wr(8'(4 * n), tw(n, 1'b0), 1'b0);
        for (int k = 0; k < 4; k++)
            wr(8'(8'h34 + 4 * k), tw(tn[k], 1'b1), 1'b0);
        wr(SYC_OFF_PFD, 32'(p), 1'b0);
        wr(SYC_OFF_WAIT, 32'h3, 1'b0);
        wr(SYC_OFF_CTRL, c, 1'b0);
        wr(SYC_OFF_TABLE, 32'h0, 1'b1);
        for (int k = 0; k < 9000 && st[1] !== 1'b1; k++)
            apb(1'b0, SYC_OFF_STATUS, 32'h0, st, e);
        chk(32'(u_dev.adc_div), 32'(adiv(p)));
        rd(SYC_OFF_STATUS, 32'h00ff0003, {8'h0, adiv(p), 16'h2}, 1'b0);
        rd(SYC_OFF_CTRL, 32'hffffffff, c & 32'hc, 1'b0);
        wr(SYC_OFF_CTRL, (c & 32'hc) | 32'h10, 1'b0);
        rd(SYC_OFF_STATUS, 32'h3, 32'h0, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(SYC_OFF_WAIT, 32'hffffffff, 32'h00004e9d, 1'b0);
        rd(SYC_OFF_PFD, 32'hffffffff, 32'h0, 1'b0);
        rd(SYC_OFF_CTRL, 32'hffffffff, 32'h0, 1'b0);
        rd(SYC_OFF_STATUS, 32'hffffffff, 32'h00010000, 1'b0);
        rd(8'h20, 32'hffffffff, 32'h0, 1'b0);
        rd(8'h54, 32'hffffffff, 32'h0, 1'b1);
        wr(SYC_OFF_STATUS, 32'h1, 1'b1);
        wr(8'h46, 32'h1, 1'b1);
        chk(32'(u_dev.wlog.size()), 32'h0);
    endtask

    task automatic t_power_low();
        int q[$];
        run(615, 32'h9);
        for (int n = 12; n > 0; n--)
            q.push_back(n * 16);
        q.push_back(0);
        seqchk(q, 12);
    endtask

    task automatic t_update_low();
        int q[$];
        run(615, 32'ha);
        q = {160, 65, 32, 16, 3, 66, 4};
        seqchk(q, 6);
    endtask

    task automatic t_power_high();
        int q[$];
        run(1200, 32'h5);
        for (int n = 12; n > 0; n--)
            q.push_back(n * 16);
        q = {q, 4, 320, 288, 272, 259};
        seqchk(q, 12);
    endtask

    task automatic t_update_high();
        int q[$];
        run(1200, 32'h6);
        q = {160, 65, 32, 16, 3, 66, 4, 320, 288, 272, 259};
        seqchk(q, 6);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        req = '0;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_power_low();
        t_update_low();
        t_power_high();
        t_update_high();
        results();
    end
endmodule

bind syc_ctrl syc_ctrl_assertions #(.CLK_DIV(CLK_DIV)) u_chk (
    .pclk    (pclk),
    .presetn (presetn),
    .apb_req (apb_req),
    .apb_rsp (apb_rsp),
    .pins    (pins)
);
